// File: hw/sfl_top.sv
// Chosen here: register access over Wishbone and the register addresses.
module sfl_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             tx_valid_o,
  output logic      [15:0] tx_data_o,
  input  wire logic        tx_ready_i,
  input  wire logic        rx_valid_i,
  input  wire logic [15:0] rx_data_i,
  output logic             rx_ready_o
);

  typedef struct packed {
    sfl_pkg::sfl_bus_st_t st;
    logic                 ack;
    logic [31:0]          dat;
    logic                 wide;
    logic [5:0]           tx_wp;
    logic [5:0]           tx_rp;
    logic [6:0]           tx_cnt;
    logic                 tx_pend;
    logic                 tx_vld;
    logic [15:0]          tx_dat;
    logic [5:0]           rx_wp;
    logic [5:0]           rx_rp;
    logic [6:0]           rx_cnt;
    logic [1:0]           rb_cnt;
    logic [15:0]          rb_d0;
    logic [15:0]          rb_d1;
    logic                 rx_rdy;
  } sfl_state_t;

  localparam sfl_state_t STATE_RESET = '{
    st:      sfl_pkg::ST_IDLE,
    wide:    sfl_pkg::WIDE_RESET,
    tx_cnt:  sfl_pkg::CNT_RESET,
    rx_cnt:  sfl_pkg::CNT_RESET,
    default: '0
  };

  sfl_state_t  state_reg;
  sfl_state_t  state_next;

  logic [6:0]  fifo_depth;
  logic [6:0]  tx_free;
  logic [6:0]  rx_free;
  logic        bus_req;
  logic        tx_push;
  logic        tx_pop;
  logic        tx_take;
  logic        rx_pop;
  logic        rx_fill;
  logic        rx_accept;
  logic        mode_flush;
  logic [1:0]  rb_left;
  logic [31:0] rd_word;
  logic [15:0] wr_word;
  logic [15:0] rx_word;

  sfl_mem_if tx_mif ();
  sfl_mem_if rx_mif ();

  sfl_mem u_tx_mem (
    .clk_i  (clk_i),
    .port_s (tx_mif.store)
  );

  sfl_mem u_rx_mem (
    .clk_i  (clk_i),
    .port_s (rx_mif.store)
  );

  // Both FIFOs share one capacity that follows the word mode
  assign fifo_depth = state_reg.wide ? sfl_pkg::DEPTH_16BIT : sfl_pkg::DEPTH_8BIT;
  assign tx_free    = fifo_depth - state_reg.tx_cnt;
  assign rx_free    = fifo_depth - state_reg.rx_cnt;

  assign bus_req = wb_cyc_i && wb_stb_i;
  assign wr_word = state_reg.wide ? wb_dat_i[15:0] : {8'h00, wb_dat_i[7:0]};
  assign rx_word = state_reg.wide ? rx_mif.rdata : {8'h00, rx_mif.rdata[7:0]};

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (wb_adr_i)
      sfl_pkg::ADR_CTRL: begin
        rd_word[sfl_pkg::CTRL_WIDE_BIT] = state_reg.wide;
      end
      sfl_pkg::ADR_STATUS: begin
        rd_word[sfl_pkg::TX_FREE_MSB:sfl_pkg::TX_FREE_LSB] = tx_free;
        rd_word[sfl_pkg::RX_FREE_MSB:sfl_pkg::RX_FREE_LSB] = rx_free;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    state_next   = state_reg;
    tx_push      = 1'b0;
    tx_pop       = 1'b0;
    rx_pop       = 1'b0;
    rx_fill      = 1'b0;
    mode_flush   = 1'b0;
    rb_left      = state_reg.rb_cnt;
    tx_take      = state_reg.tx_vld && tx_ready_i;
    rx_accept    = rx_valid_i && state_reg.rx_rdy;
    tx_mif.we    = 1'b0;
    tx_mif.waddr = state_reg.tx_wp;
    tx_mif.wdata = wr_word;
    tx_mif.re    = 1'b0;
    tx_mif.raddr = state_reg.tx_rp;
    rx_mif.we    = 1'b0;
    rx_mif.waddr = state_reg.rx_wp;
    rx_mif.wdata = state_reg.rb_d0;
    rx_mif.re    = 1'b0;
    rx_mif.raddr = state_reg.rx_rp;

    // Register bus: one request per pass through IDLE
    unique case (state_reg.st)
      sfl_pkg::ST_IDLE: begin
        if (bus_req) begin
          if (wb_we_i) begin
            state_next.st  = sfl_pkg::ST_ACK;
            state_next.ack = 1'b1;
            state_next.dat = 32'h0000_0000;
            if (wb_adr_i == sfl_pkg::ADR_CTRL && wb_sel_i[0]) begin
              state_next.wide = wb_dat_i[sfl_pkg::CTRL_WIDE_BIT];
              mode_flush      = wb_dat_i[sfl_pkg::CTRL_WIDE_BIT] != state_reg.wide;
            end
            // A write into a full transmit FIFO is dropped
            if (wb_adr_i == sfl_pkg::ADR_DATA && wb_sel_i[0] && state_reg.tx_cnt != fifo_depth) begin
              tx_push = 1'b1;
            end
          end else if (wb_adr_i == sfl_pkg::ADR_DATA && state_reg.rx_cnt != sfl_pkg::CNT_RESET) begin
            rx_pop        = 1'b1;
            state_next.st = sfl_pkg::ST_RDMEM;
          end else begin
            state_next.st  = sfl_pkg::ST_ACK;
            state_next.ack = 1'b1;
            state_next.dat = rd_word;
          end
        end
      end
      sfl_pkg::ST_RDMEM: begin
        state_next.st  = sfl_pkg::ST_ACK;
        state_next.ack = 1'b1;
        state_next.dat = {16'h0000, rx_word};
      end
      sfl_pkg::ST_ACK: begin
        state_next.st  = sfl_pkg::ST_IDLE;
        state_next.ack = 1'b0;
      end
    endcase

    if (tx_push) begin
      tx_mif.we        = 1'b1;
      state_next.tx_wp = state_reg.tx_wp + sfl_pkg::PTR_STEP;
    end

    // Transmit output stage: a word leaves the count when its read is issued
    if (tx_take) begin
      state_next.tx_vld = 1'b0;
    end
    if (state_reg.tx_pend) begin
      state_next.tx_vld  = 1'b1;
      state_next.tx_dat  = tx_mif.rdata;
      state_next.tx_pend = 1'b0;
    end else if ((!state_reg.tx_vld || tx_take) && state_reg.tx_cnt != sfl_pkg::CNT_RESET) begin
      tx_pop             = 1'b1;
      tx_mif.re          = 1'b1;
      state_next.tx_pend = 1'b1;
      state_next.tx_rp   = state_reg.tx_rp + sfl_pkg::PTR_STEP;
    end

    unique case ({tx_push, tx_pop})
      2'b10:   state_next.tx_cnt = state_reg.tx_cnt + sfl_pkg::CNT_STEP;
      2'b01:   state_next.tx_cnt = state_reg.tx_cnt - sfl_pkg::CNT_STEP;
      default: state_next.tx_cnt = state_reg.tx_cnt;
    endcase

    if (rx_pop) begin
      rx_mif.re        = 1'b1;
      state_next.rx_rp = state_reg.rx_rp + sfl_pkg::PTR_STEP;
    end

    // Two-entry receive buffer drains only while the receive FIFO has room
    if (state_reg.rb_cnt != 2'h0 && state_reg.rx_cnt != fifo_depth) begin
      rx_fill          = 1'b1;
      rx_mif.we        = 1'b1;
      state_next.rx_wp = state_reg.rx_wp + sfl_pkg::PTR_STEP;
      state_next.rb_d0 = state_reg.rb_d1;
      rb_left          = state_reg.rb_cnt - sfl_pkg::RBUF_STEP;
    end
    if (rx_accept) begin
      if (rb_left == 2'h0) begin
        state_next.rb_d0 = rx_data_i;
      end else begin
        state_next.rb_d1 = rx_data_i;
      end
      state_next.rb_cnt = rb_left + sfl_pkg::RBUF_STEP;
    end else begin
      state_next.rb_cnt = rb_left;
    end
    // Ready is registered, so it looks at the slot count one cycle ahead
    state_next.rx_rdy = state_next.rb_cnt != sfl_pkg::RBUF_SLOTS;

    unique case ({rx_fill, rx_pop})
      2'b10:   state_next.rx_cnt = state_reg.rx_cnt + sfl_pkg::CNT_STEP;
      2'b01:   state_next.rx_cnt = state_reg.rx_cnt - sfl_pkg::CNT_STEP;
      default: state_next.rx_cnt = state_reg.rx_cnt;
    endcase

    // Changing word width discards the words in both FIFOs and the transmit output stage; the old layout is meaningless
    if (mode_flush) begin
      state_next.tx_wp   = 6'h00;
      state_next.tx_rp   = 6'h00;
      state_next.tx_cnt  = sfl_pkg::CNT_RESET;
      state_next.tx_pend = 1'b0;
      state_next.tx_vld  = 1'b0;
      state_next.rx_wp   = 6'h00;
      state_next.rx_rp   = 6'h00;
      state_next.rx_cnt  = sfl_pkg::CNT_RESET;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign wb_dat_o   = state_reg.dat;
  assign wb_ack_o   = state_reg.ack;
  assign tx_valid_o = state_reg.tx_vld;
  assign tx_data_o  = state_reg.tx_dat;
  assign rx_ready_o = state_reg.rx_rdy;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_status_req;
    state_reg.st == sfl_pkg::ST_IDLE && bus_req && !wb_we_i && wb_adr_i == sfl_pkg::ADR_STATUS;
  endsequence

  sequence s_bus_answer;
    wb_ack_o && state_reg.st == sfl_pkg::ST_ACK;
  endsequence

  sequence s_data_write;
    state_reg.st == sfl_pkg::ST_IDLE && bus_req && wb_we_i && wb_adr_i == sfl_pkg::ADR_DATA && wb_sel_i[0];
  endsequence

  property p_tx_field;
    s_status_req ##1 s_bus_answer |-> wb_dat_o[15:9] == $past(tx_free) && wb_dat_o[31:23] == 9'h000;
  endproperty

  property p_rx_field;
    s_status_req ##1 s_bus_answer |-> wb_dat_o[22:16] == $past(rx_free) && wb_dat_o[8:0] == 9'h000;
  endproperty

  AST_TX_FIELD : assert property (p_tx_field) else $error("Transmit free field wrong");
  AST_TX_CAP8 : assert property (!state_reg.wide |-> state_reg.tx_cnt <= 7'h40) else $error("Tx over 64");
  AST_TX_CAP16 : assert property ((state_reg.wide && state_reg.tx_cnt == 7'h20 && !mode_flush) ##0 s_data_write
                                  |=> state_reg.tx_cnt <= 7'h20) else $error("Tx grew past 32");
  AST_TX_FULL : assert property ((state_reg.tx_cnt == fifo_depth) ##0 s_data_write
                                 |=> state_reg.tx_cnt <= $past(state_reg.tx_cnt) && !$past(tx_mif.we))
                else $error("Push into full tx");
  AST_TX_EMPTY8 : assert property (!state_reg.wide && state_reg.tx_cnt == 7'h00 |-> tx_free == 7'h40)
                  else $error("Empty tx 8-bit not 64");
  AST_TX_EMPTY16 : assert property (state_reg.wide && state_reg.tx_cnt == 7'h00 |-> tx_free == 7'h20)
                   else $error("Empty tx 16-bit not 32");
  AST_RX_FIELD : assert property (p_rx_field) else $error("Receive free field wrong");
  AST_RX_CAP8 : assert property (!state_reg.wide |-> state_reg.rx_cnt <= 7'h40) else $error("Rx over 64");
  AST_RX_FULL : assert property (state_reg.rx_cnt == fifo_depth |-> !rx_mif.we && rx_free == 7'h00)
                else $error("Fill into full rx");
  AST_RX_EMPTY16 : assert property (state_reg.wide && state_reg.rx_cnt == 7'h00 |-> rx_free == 7'h20)
                   else $error("Empty rx 16-bit not 32");
  AST_RX_EMPTY8 : assert property (!state_reg.wide && state_reg.rx_cnt == 7'h00 |-> rx_free == 7'h40)
                  else $error("Empty rx 8-bit not 64");
  AST_TX_COUNT : assert property (tx_push && !tx_pop && !mode_flush
                                  |=> state_reg.tx_cnt == $past(state_reg.tx_cnt) + 7'h01) else $error("Tx count missed push");
  AST_RX_COUNT : assert property (rx_pop && !rx_fill
                                  |=> state_reg.rx_cnt == $past(state_reg.rx_cnt) - 7'h01) else $error("Rx count missed pop");
  AST_RX_CAP16 : assert property (state_reg.wide |-> state_reg.rx_cnt <= 7'h20) else $error("Rx over 32");

  // Read of the data word: an empty receive FIFO answers at once with zero
  sequence s_data_read;
    state_reg.st == sfl_pkg::ST_IDLE && bus_req && !wb_we_i && wb_adr_i == sfl_pkg::ADR_DATA;
  endsequence

  sequence s_late_answer;
    !wb_ack_o ##1 s_bus_answer;
  endsequence

  AST_TX_FREE_MAX : assert property (tx_free <= fifo_depth)
                    else $error("Tx free above depth");
  AST_RX_FREE_MAX : assert property (rx_free <= fifo_depth)
                    else $error("Rx free above depth");
  AST_ACK_PULSE : assert property (wb_ack_o |=> !wb_ack_o)
                  else $error("Ack held past one cycle");
  AST_STATUS_LAT : assert property (s_status_req |=> s_bus_answer)
                   else $error("Status read not answered next cycle");
  AST_EMPTY_POP : assert property (s_data_read ##0 (state_reg.rx_cnt == 7'h00)
                                   |=> s_bus_answer and wb_dat_o == 32'h0000_0000) else $error("Empty rx read not zero");
  AST_POP_LAT : assert property (s_data_read ##0 (state_reg.rx_cnt != 7'h00) |=> s_late_answer)
                else $error("Rx pop answer not two cycles");
  AST_TX_POP_COUNT : assert property (tx_pop && !tx_push && !mode_flush
                                      |=> state_reg.tx_cnt == $past(state_reg.tx_cnt) - 7'h01)
                     else $error("Tx count missed pop");
  AST_RX_FILL_COUNT : assert property (rx_fill && !rx_pop && !mode_flush
                                       |=> state_reg.rx_cnt == $past(state_reg.rx_cnt) + 7'h01)
                      else $error("Rx count missed fill");
  AST_FLUSH_EMPTY : assert property (mode_flush |=> tx_free == fifo_depth && rx_free == fifo_depth)
                    else $error("Mode change left words behind");
  // Registered ready must already be low once the second slot is taken
  AST_RB_READY : assert property (state_reg.rb_cnt == sfl_pkg::RBUF_SLOTS |-> !rx_ready_o)
                 else $error("Ready with both buffer slots full");
  // A word in the output stage no longer counts, so it must stand until taken
  AST_TX_HOLD : assert property (tx_valid_o && !tx_ready_i && !mode_flush
                                 |=> tx_valid_o && $stable(tx_data_o)) else $error("Tx word changed before taken");

endmodule : sfl_top

// File: hw/sfl_pkg.sv
package sfl_pkg;

  // Byte addresses of the register words on the bus
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_DATA   = 8'h08;

  // Field positions
  localparam int CTRL_WIDE_BIT = 0;
  localparam int TX_FREE_LSB   = 9;
  localparam int TX_FREE_MSB   = 15;
  localparam int RX_FREE_LSB   = 16;
  localparam int RX_FREE_MSB   = 22;

  // Storage geometry and per-mode capacity
  localparam int         MEM_ADDR_W  = 6;
  localparam int         MEM_DATA_W  = 16;
  localparam int         MEM_WORDS   = 64;
  localparam logic [6:0] DEPTH_8BIT  = 7'h40;
  localparam logic [6:0] DEPTH_16BIT = 7'h20;

  // Reset values, small step constants and the receive buffer slot count
  localparam logic [6:0] CNT_RESET  = 7'h00;
  localparam logic [6:0] CNT_STEP   = 7'h01;
  localparam logic [5:0] PTR_STEP   = 6'h01;
  localparam logic       WIDE_RESET = 1'b0;
  localparam logic [1:0] RBUF_SLOTS = 2'h2;
  localparam logic [1:0] RBUF_STEP  = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_RDMEM = 3'b010,
    ST_ACK   = 3'b100
  } sfl_bus_st_t;

endpackage : sfl_pkg

// File: hw/sfl_mem_if.sv
interface sfl_mem_if;
  logic        we;
  logic [5:0]  waddr;
  logic [15:0] wdata;
  logic        re;
  logic [5:0]  raddr;
  logic [15:0] rdata;

  modport ctrl  (output we, output waddr, output wdata, output re, output raddr, input rdata);
  modport store (input we, input waddr, input wdata, input re, input raddr, output rdata);
endinterface : sfl_mem_if

// File: hw/sfl_mem.sv
module sfl_mem (
  input  wire logic  clk_i,
  sfl_mem_if.store   port_s
);

  logic [sfl_pkg::MEM_DATA_W-1:0] mem_reg [0:sfl_pkg::MEM_WORDS-1];

  // Read data comes from a register, one cycle after the read strobe
  always_ff @(posedge clk_i) begin
    if (port_s.we) begin
      mem_reg[port_s.waddr] <= port_s.wdata;
    end
    if (port_s.re) begin
      port_s.rdata <= mem_reg[port_s.raddr];
    end
  end

endmodule : sfl_mem

// File: sim/sfl_far.sv
module sfl_far (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        tx_valid_i,
  input  wire logic [15:0] tx_data_i,
  output logic             tx_ready_o,
  input  wire logic        stall_i,
  input  wire logic        rx_en_i,
  output logic             rx_valid_o,
  output logic      [15:0] rx_data_o,
  input  wire logic        rx_ready_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] got[$];
  logic [15:0] word_reg;
  assign tx_ready_o = !stall_i;
  // Data line shows the inverse of the word while nothing is offered
  assign rx_data_o  = rx_valid_o ? word_reg : ~word_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_valid_o <= 1'b0;
      word_reg   <= 16'hA000;
    end else begin
      rx_valid_o <= rx_en_i;
      if (rx_valid_o && rx_ready_i) begin
        word_reg <= word_reg + 16'h0001;
      end
      if (tx_valid_i && tx_ready_o) begin
        got.push_back(tx_data_i);
      end
    end
  end
endmodule : sfl_far

// File: sim/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, wb_dat_o, q;
  logic        wb_ack_o, tx_valid_o, tx_ready, rx_valid, rx_ready_o;
  logic        stall = 1'b1, rx_en = 1'b0;
  logic [15:0] tx_data_o, rx_data;
  int          errors = 0, comparisons = 0;
  always #2 clk_i = ~clk_i;
  sfl_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready),
    .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_ready_o(rx_ready_o));
  sfl_far far (.clk_i(clk_i), .rst_i(rst_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
    .tx_ready_o(tx_ready), .stall_i(stall), .rx_en_i(rx_en), .rx_valid_o(rx_valid),
    .rx_data_o(rx_data), .rx_ready_i(rx_ready_o));
  task test_done;
    if (errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  // Holds the request until ack is sampled, then releases for one idle cycle
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    r = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      errors++;
      test_done();
    end
  endtask : wb
  task chk_st(input logic [6:0] tx, input logic [6:0] rx);
    wb(1'b0, sfl_pkg::ADR_STATUS, 32'h0, q);
    check(q, {9'h000, rx, tx, 9'h000});
  endtask : chk_st
  task poll(input int lsb, input logic [6:0] exp);
    int n;
    n = 0;
    do begin
      wb(1'b0, sfl_pkg::ADR_STATUS, 32'h0, q);
      n++;
    end while (q[lsb +: 7] !== exp && n < 200);
    if (q[lsb +: 7] !== exp) begin
      errors++;
      test_done();
    end
  endtask : poll
  task push(input int cnt, input logic [15:0] base);
    for (int i = 0; i < cnt; i++) wb(1'b1, sfl_pkg::ADR_DATA, {16'h0, base + 16'(i)}, q);
  endtask : push
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_st(7'h40, 7'h40);
    // Empty receive read answers zero; status ignores writes
    wb(1'b0, sfl_pkg::ADR_DATA, 32'h0, q);
    check(q, 32'h0);
    wb(1'b1, sfl_pkg::ADR_STATUS, 32'hFFFF_FFFF, q);
    check(q, 32'h0);
    chk_st(7'h40, 7'h40);
    // Output stage takes the first word, so 65 pushes fill the 64 slots
    push(64, 16'h0010);
    chk_st(7'h01, 7'h40);
    push(2, 16'h00F0);
    chk_st(7'h00, 7'h40);
    wb(1'b0, 8'h10, 32'h0, q);
    check(q, 32'h0);
    wb(1'b1, sfl_pkg::ADR_CTRL, 32'h1, q);
    wb(1'b0, sfl_pkg::ADR_CTRL, 32'h0, q);
    check(q, 32'h1);
    chk_st(7'h20, 7'h20);
    push(2, 16'hBEEF);
    chk_st(7'h1F, 7'h20);
    push(31, 16'h1000);
    chk_st(7'h00, 7'h20);
    stall <= 1'b0;
    poll(sfl_pkg::TX_FREE_LSB, 7'h20);
    // The last word may still sit in the output stage when the count reads empty
    repeat (4) @(posedge clk_i);
    check({16'h0, far.got[0]}, 32'h0000BEEF);
    check({16'h0, far.got[1]}, 32'h0000BEF0);
    check({16'h0, far.got[32]}, 32'h0000101E);
    check(far.got.size(), 32'h21);
    rx_en <= 1'b1;
    poll(sfl_pkg::RX_FREE_LSB, 7'h00);
    chk_st(7'h20, 7'h00);
    wb(1'b0, sfl_pkg::ADR_DATA, 32'h0, q);
    check(q, 32'h0000A000);
    // Flush keeps the two buffered words, 16'hA021 first
    wb(1'b1, sfl_pkg::ADR_CTRL, 32'h0, q);
    poll(sfl_pkg::RX_FREE_LSB, 7'h00);
    chk_st(7'h40, 7'h00);
    wb(1'b0, sfl_pkg::ADR_DATA, 32'h0, q);
    check(q, 32'h0000_0021);
    test_done();
  end
endmodule : tb
